/* eeprom_link_pkg.sv */
`default_nettype none
package eeprom_link_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned NOISE_FILTER_NS = 100;
	// A pulse this many samples long or shorter is dropped.
	localparam logic [3:0] NOISE_FILTER_CYC =
		4'((NOISE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int unsigned POWER_UP_READY_DELAY_MS = 1;
	localparam int unsigned PU_CYC_DEF =
		POWER_UP_READY_DELAY_MS * 1000 * 1000 / CLK_PERIOD_NS;
	localparam int unsigned WRITE_CYCLE_MS = 5;
	localparam int unsigned WR_CYC_DEF =
		WRITE_CYCLE_MS * 1000 * 1000 / CLK_PERIOD_NS;
	localparam int unsigned SCL_PERIOD_NS = 10000;
	localparam logic [11:0] SCL_QTR_CYC =
		12'(SCL_PERIOD_NS / 4 / CLK_PERIOD_NS);

	// ---------------------------------------------------------------
	// Slave address layout
	// ---------------------------------------------------------------
	localparam logic [3:0] DEV_TYPE = 4'hA;

	// ---------------------------------------------------------------
	// Master register map
	// ---------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] DATA_OFS = 8'h04;
	localparam logic [7:0] STAT_OFS = 8'h08;
	localparam int unsigned CTRL_ACK_BIT = 8;
	localparam int unsigned STAT_BUSY_BIT = 0;
	localparam int unsigned STAT_READY_BIT = 1;
	localparam int unsigned STAT_ACK_BIT = 2;
	localparam int unsigned STAT_OWN_BIT = 3;
	localparam logic [1:0] CMD_START = 2'h0;
	localparam logic [1:0] CMD_STOP = 2'h1;
	localparam logic [1:0] CMD_WRITE = 2'h2;
	localparam logic [1:0] CMD_READ = 2'h3;

	// Reset value of the slave pin synchroniser: clock and data idle high.
	localparam logic [6:0] PIN_SYNC_RST = 7'h03;

endpackage
`default_nettype wire

/* eeprom_link_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface eeprom_link_if;
	logic scl;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic sda;

	// Open-drain wired AND with the pull-up standing in for a released line.
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

	modport host (
		output scl,
		output host_sda_o,
		output host_sda_oe,
		input  sda
	);
	modport dev (
		input  scl,
		input  sda,
		output dev_sda_o,
		output dev_sda_oe
	);
endinterface
`default_nettype wire

/* eeprom_slave_end.sv */
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// Overview of operation
// - Sample data on clock rise, change on fall.
// - Data output only pulls low or releases.
// - Supply loss resets; supply return restarts.
// - Answer only when select bits match straps.
// - Floating address straps read as low.
// - Write inhibit high refuses memory writes.
// - Floating write inhibit reads low, writes allowed.
// - Slave only; master assigns transfer roles.
// - Master makes the clock; slave only listens.
// - Zero pulls line low, one releases.
// - Master starts only on an idle bus.
// - Data stays stable while clock is high.
// - Master waits power-up delay before commands.
// - Pulses up to 100 ns are filtered.
// - Address high nibble 1010, select, direction.
// - Data fall/rise with clock high: start/stop.
// - Ninth clock: receiver acknowledges or declines.
// - No address acknowledge during write cycle.
// ---------------------------------------------------------------
module eeprom_slave_end #(
	parameter int unsigned PU_CYC = eeprom_link_pkg::PU_CYC_DEF,
	parameter int unsigned WR_CYC = eeprom_link_pkg::WR_CYC_DEF
) (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       clk_en,
	input  wire logic       supply_ok,
	input  wire logic       select_strap_bit0,
	input  wire logic       select_strap_bit1,
	input  wire logic       select_strap_bit2,
	input  wire logic       write_inhibit,
	eeprom_link_if.dev      link,
	input  wire logic [7:0] tx_data,
	output logic            tx_taken,
	output logic [7:0]      rx_data,
	output logic            rx_valid,
	output logic            write_commit,
	output logic            write_busy,
	output logic            dev_ready
);
	import eeprom_link_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_RX     = 3'b001,
		ST_RX_ACK = 3'b010,
		ST_TX     = 3'b011,
		ST_TX_ACK = 3'b100
	} slave_state_e;

	// ---------------------------------------------------------------
	// Pin synchronisers and glitch filters
	// ---------------------------------------------------------------
	logic [6:0]  sync1_q;
	logic [6:0]  sync2_q;
	logic [1:0]  filt;
	logic [1:0]  prev_q;
	logic        hold;
	logic [19:0] pu_cnt_q;
	logic        ready_q;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sync1_q <= PIN_SYNC_RST;
			sync2_q <= PIN_SYNC_RST;
		end else if (clk_en) begin
			// The pads pull floating straps and inhibit low.
			sync1_q <= {write_inhibit, select_strap_bit2, select_strap_bit1,
				select_strap_bit0, supply_ok, link.sda, link.scl};
			sync2_q <= sync1_q;
		end
	end

	// Bit 0 is the clock, bit 1 the data line.
	for (genvar i = 0; i < 2; i++) begin : g_filt
		logic [3:0] cnt_q;
		logic       f_q;
		always_ff @(posedge sys_clk) begin
			if (rst) begin
				cnt_q <= 4'h0;
				f_q <= 1'b1;
			end else if (clk_en) begin
				if (sync2_q[i] == f_q) begin
					cnt_q <= 4'h0;
				end else if (cnt_q == NOISE_FILTER_CYC) begin
					f_q <= sync2_q[i];
					cnt_q <= 4'h0;
				end else begin
					cnt_q <= cnt_q + 4'h1;
				end
			end
		end
		assign filt[i] = f_q;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			prev_q <= 2'h3;
		end else if (clk_en) begin
			prev_q <= filt;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic sda_f;

	assign sda_f = filt[1];
	assign scl_rise = filt[0] & ~prev_q[0];
	assign scl_fall = ~filt[0] & prev_q[0];
	assign start_det = filt[0] & prev_q[0] & ~sda_f & prev_q[1];
	assign stop_det = filt[0] & prev_q[0] & sda_f & ~prev_q[1];

	// ---------------------------------------------------------------
	// Power-on reset and power-up ready delay
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pu_cnt_q <= 20'h0;
			ready_q <= 1'b0;
		end else if (clk_en && !sync2_q[2]) begin
			pu_cnt_q <= 20'h0;
			ready_q <= 1'b0;
		end else if (clk_en && !ready_q) begin
			if (pu_cnt_q == 20'(PU_CYC - 1)) begin
				ready_q <= 1'b1;
			end else begin
				pu_cnt_q <= pu_cnt_q + 20'h1;
			end
		end
	end

	// A brown-out drops the block back into reset until ready again.
	assign hold = rst | ~ready_q;

	// ---------------------------------------------------------------
	// Byte engine
	// ---------------------------------------------------------------
	slave_state_e state_q;
	logic [3:0]   bit_cnt_q;
	logic [7:0]   shreg_q;
	logic [7:0]   rx_byte;
	logic [1:0]   byte_idx_q;
	logic         is_addr_q;
	logic         reading_q;
	logic         ack_q;
	logic         mack_q;
	logic         pull_q;
	logic         wr_pend_q;
	logic         tx_taken_q;
	logic         rx_valid_q;
	logic [7:0]   rx_data_q;
	logic [19:0]  busy_cnt_q;
	logic         busy_q;
	logic         commit_q;
	logic         addr_hit;
	logic         refuse;

	assign rx_byte = {shreg_q[6:0], sda_f};
	assign addr_hit = (rx_byte[7:4] == DEV_TYPE)
		&& (rx_byte[3:1] == sync2_q[5:3])
		&& (busy_cnt_q == 20'h0);
	// Only data bytes, not the memory address bytes, are refused.
	assign refuse = (byte_idx_q == 2'h2) && sync2_q[6];

	always_ff @(posedge sys_clk) begin
		if (hold) begin
			state_q <= ST_IDLE;
			bit_cnt_q <= 4'h0;
			shreg_q <= 8'h00;
			byte_idx_q <= 2'h0;
			is_addr_q <= 1'b0;
			reading_q <= 1'b0;
			ack_q <= 1'b0;
			mack_q <= 1'b0;
			pull_q <= 1'b0;
			wr_pend_q <= 1'b0;
			tx_taken_q <= 1'b0;
			rx_valid_q <= 1'b0;
			rx_data_q <= 8'h00;
		end else if (clk_en) begin
			tx_taken_q <= 1'b0;
			rx_valid_q <= 1'b0;
			if (stop_det) begin
				state_q <= ST_IDLE;
				pull_q <= 1'b0;
				wr_pend_q <= 1'b0;
			end else if (start_det) begin
				state_q <= ST_RX;
				bit_cnt_q <= 4'h0;
				is_addr_q <= 1'b1;
				byte_idx_q <= 2'h0;
				pull_q <= 1'b0;
			end else begin
				case (state_q)
				ST_RX: begin
					if (scl_rise) begin
						shreg_q <= rx_byte;
						bit_cnt_q <= bit_cnt_q + 4'h1;
						if (bit_cnt_q == 4'h7 && is_addr_q) begin
							ack_q <= addr_hit;
							reading_q <= sda_f;
						end else if (bit_cnt_q == 4'h7) begin
							ack_q <= ~refuse;
							rx_valid_q <= ~refuse;
							rx_data_q <= rx_byte;
							wr_pend_q <= wr_pend_q | (byte_idx_q == 2'h2 && !refuse);
						end
					end else if (scl_fall && bit_cnt_q == 4'h8) begin
						state_q <= ST_RX_ACK;
						pull_q <= ack_q;
					end
				end
				ST_RX_ACK: begin
					if (scl_fall) begin
						bit_cnt_q <= 4'h0;
						is_addr_q <= 1'b0;
						if (!is_addr_q && byte_idx_q != 2'h2) begin
							byte_idx_q <= byte_idx_q + 2'h1;
						end
						if (!ack_q) begin
							state_q <= ST_IDLE;
							pull_q <= 1'b0;
						end else if (reading_q) begin
							state_q <= ST_TX;
							shreg_q <= tx_data;
							pull_q <= ~tx_data[7];
							tx_taken_q <= 1'b1;
						end else begin
							state_q <= ST_RX;
							pull_q <= 1'b0;
						end
					end
				end
				ST_TX: begin
					if (scl_rise) begin
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end else if (scl_fall && bit_cnt_q == 4'h8) begin
						state_q <= ST_TX_ACK;
						pull_q <= 1'b0;
					end else if (scl_fall) begin
						shreg_q <= {shreg_q[6:0], 1'b0};
						pull_q <= ~shreg_q[6];
					end
				end
				ST_TX_ACK: begin
					if (scl_rise) begin
						mack_q <= ~sda_f;
					end else if (scl_fall && mack_q) begin
						state_q <= ST_TX;
						bit_cnt_q <= 4'h0;
						shreg_q <= tx_data;
						pull_q <= ~tx_data[7];
						tx_taken_q <= 1'b1;
					end else if (scl_fall) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
					pull_q <= 1'b0;
				end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Internal write cycle timer
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (hold) begin
			busy_cnt_q <= 20'h0;
			busy_q <= 1'b0;
			commit_q <= 1'b0;
		end else if (clk_en) begin
			commit_q <= stop_det & wr_pend_q;
			if (stop_det && wr_pend_q) begin
				busy_cnt_q <= 20'(WR_CYC);
				busy_q <= 1'b1;
			end else if (busy_cnt_q != 20'h0) begin
				busy_cnt_q <= busy_cnt_q - 20'h1;
				busy_q <= (busy_cnt_q != 20'h1);
			end
		end
	end

	// Never drive high: the data level is fixed low.
	assign link.dev_sda_o = 1'b0;
	assign link.dev_sda_oe = pull_q;
	assign tx_taken = tx_taken_q;
	assign rx_data = rx_data_q;
	assign rx_valid = rx_valid_q;
	assign write_commit = commit_q;
	assign write_busy = busy_q;
	assign dev_ready = ready_q;
endmodule
`default_nettype wire

/* eeprom_master_end.sv */
`timescale 1ns/100ps
`default_nettype none
module eeprom_master_end #(
	parameter int unsigned PU_CYC = eeprom_link_pkg::PU_CYC_DEF
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        clk_en,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	eeprom_link_if.host      link
);
	import eeprom_link_pkg::*;

	typedef enum logic [1:0] {
		H_IDLE  = 2'b00,
		H_START = 2'b01,
		H_BIT   = 2'b10,
		H_STOP  = 2'b11
	} host_state_e;

	host_state_e state_q;
	logic        sda_s1_q;
	logic        sda_s2_q;
	logic [19:0] pu_cnt_q;
	logic        ready_q;
	logic [11:0] qcnt_q;
	logic [1:0]  phase_q;
	logic [3:0]  bit_q;
	logic [7:0]  sh_q;
	logic [7:0]  txd_q;
	logic        wr_q;
	logic        ack_en_q;
	logic        ack_seen_q;
	logic        owned_q;
	logic        scl_q;
	logic        pull_q;
	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] prdata_q;
	logic        tick;
	logic        acc;
	logic        go;

	// ---------------------------------------------------------------
	// Data line synchroniser and power-up wait
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
		end else if (clk_en) begin
			sda_s1_q <= link.sda;
			sda_s2_q <= sda_s1_q;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pu_cnt_q <= 20'h0;
			ready_q <= 1'b0;
		end else if (clk_en && !ready_q) begin
			if (pu_cnt_q == 20'(PU_CYC - 1)) begin
				ready_q <= 1'b1;
			end else begin
				pu_cnt_q <= pu_cnt_q + 20'h1;
			end
		end
	end

	// ---------------------------------------------------------------
	// APB slave
	// ---------------------------------------------------------------
	assign acc = psel & penable & pready_q;
	// Commands are taken only when idle and ready; a start needs the bus ours or free, other commands need it ours.
	assign go = acc && pwrite && paddr == CTRL_OFS && state_q == H_IDLE
		&& ready_q && (pwdata[1:0] == CMD_START ? (owned_q | sda_s2_q)
		: owned_q);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
			txd_q <= 8'h00;
		end else if (clk_en) begin
			pready_q <= psel & ~penable & ~pready_q;
			if (psel && !penable) begin
				pslverr_q <= !(paddr == CTRL_OFS || paddr == DATA_OFS
					|| paddr == STAT_OFS);
				prdata_q <= 32'h0;
				if (!pwrite && paddr == DATA_OFS) begin
					prdata_q <= {24'h0, sh_q};
				end else if (!pwrite && paddr == STAT_OFS) begin
					prdata_q[STAT_BUSY_BIT] <= (state_q != H_IDLE);
					prdata_q[STAT_READY_BIT] <= ready_q;
					prdata_q[STAT_ACK_BIT] <= ack_seen_q;
					prdata_q[STAT_OWN_BIT] <= owned_q;
				end
			end
			if (acc && pwrite && paddr == DATA_OFS) begin
				txd_q <= pwdata[7:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// Clock divider and bit engine
	// ---------------------------------------------------------------
	assign tick = (qcnt_q == SCL_QTR_CYC - 12'h1);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= H_IDLE;
			qcnt_q <= 12'h0;
			phase_q <= 2'h0;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			wr_q <= 1'b0;
			ack_en_q <= 1'b0;
			ack_seen_q <= 1'b0;
			owned_q <= 1'b0;
			scl_q <= 1'b1;
			pull_q <= 1'b0;
		end else if (clk_en) begin
			qcnt_q <= (state_q == H_IDLE || tick) ? 12'h0 : qcnt_q + 12'h1;
			if (go) begin
				phase_q <= 2'h0;
				bit_q <= 4'h0;
				sh_q <= txd_q;
				wr_q <= (pwdata[1:0] == CMD_WRITE);
				ack_en_q <= pwdata[CTRL_ACK_BIT];
				ack_seen_q <= 1'b0;
				case (pwdata[1:0])
				CMD_START: state_q <= H_START;
				CMD_STOP: state_q <= H_STOP;
				default: state_q <= H_BIT;
				endcase
			end else if (tick) begin
				phase_q <= phase_q + 2'h1;
				case (state_q)
				H_START: begin
					case (phase_q)
					2'h0: pull_q <= 1'b0;
					2'h1: scl_q <= 1'b1;
					2'h2: pull_q <= 1'b1;
					default: begin
						scl_q <= 1'b0;
						owned_q <= 1'b1;
						state_q <= H_IDLE;
					end
					endcase
				end
				H_STOP: begin
					case (phase_q)
					2'h0: pull_q <= 1'b1;
					2'h1: scl_q <= 1'b1;
					2'h2: pull_q <= 1'b0;
					default: begin
						owned_q <= 1'b0;
						state_q <= H_IDLE;
					end
					endcase
				end
				H_BIT: begin
					case (phase_q)
					2'h0: begin
						// Data changes only while the clock is low.
						if (bit_q != 4'h8) begin
							pull_q <= wr_q & ~sh_q[7];
						end else begin
							pull_q <= ~wr_q & ack_en_q;
						end
					end
					2'h1: scl_q <= 1'b1;
					2'h2: begin
						if (bit_q != 4'h8) begin
							sh_q <= {sh_q[6:0], sda_s2_q};
						end else if (wr_q) begin
							ack_seen_q <= ~sda_s2_q;
						end
					end
					default: begin
						scl_q <= 1'b0;
						if (bit_q == 4'h8) begin
							state_q <= H_IDLE;
						end else begin
							bit_q <= bit_q + 4'h1;
						end
					end
					endcase
				end
				default: state_q <= H_IDLE;
				endcase
			end
		end
	end

	// The master alone decides direction per phase.
	assign link.scl = scl_q;
	assign link.host_sda_o = 1'b0;
	assign link.host_sda_oe = pull_q;
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
endmodule
`default_nettype wire

/* eeprom_link_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module eeprom_link_sva (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic sda
);
	// ---------------------------------------------------------------
	// Helper state
	// ---------------------------------------------------------------
	// Half a bit is 500 cycles; the bounds leave room for the quarter
	// scheduling of start and stop without tying the check to it.
	localparam int LOW_MIN  = 200;
	localparam int HIGH_MIN = 200;

	logic [15:0] run_q;
	logic        bus_busy_q;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	always_ff @(posedge sys_clk) begin
		if (rst)
			run_q <= 16'h0001;
		else if ($changed(scl))
			run_q <= 16'h0001;
		else if (run_q != 16'hFFFF)
			run_q <= run_q + 16'h0001;
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			bus_busy_q <= 1'b0;
		else if (scl && $past(scl) && $fell(sda))
			bus_busy_q <= 1'b1;
		else if (scl && $past(scl) && $rose(sda))
			bus_busy_q <= 1'b0;
	end

	// ---------------------------------------------------------------
	// Framing
	// ---------------------------------------------------------------
	sequence s_start;
		scl && $past(scl) && $fell(sda);
	endsequence

	sequence s_stop;
		scl && $past(scl) && $rose(sda);
	endsequence

	AST_DEV_OPEN_DRAIN: assert property (dev_sda_oe |-> !dev_sda_o)
		else $error("slave drives the data line high");
	AST_HOST_OPEN_DRAIN: assert property (host_sda_oe |-> !host_sda_o)
		else $error("master drives the data line high");
	AST_DEV_EDGE: assert property ($changed(dev_sda_oe) |->
		!scl && !$past(scl, 8))
		else $error("slave changed data outside the clock low phase");
	AST_DEV_STABLE: assert property (scl && $past(scl) |->
		$stable(dev_sda_oe))
		else $error("slave changed data while the clock was high");
	AST_SCL_LOW_MIN: assert property ($rose(scl) |-> run_q >= LOW_MIN)
		else $error("serial clock low phase too short");
	AST_SCL_HIGH_MIN: assert property ($fell(scl) |-> run_q >= HIGH_MIN)
		else $error("serial clock high phase too short");
	AST_IDLE_QUIET: assert property (!bus_busy_q |-> !dev_sda_oe)
		else $error("slave drives data outside a transfer");
	AST_START_BY_HOST: assert property (s_start |->
		host_sda_oe && !dev_sda_oe)
		else $error("start not made by the master alone");
	AST_STOP_HOLD: assert property (s_stop |=>
		(scl && !host_sda_oe) [*8])
		else $error("bus not left idle after stop");
	AST_RESET_RELEASE: assert property ($fell(rst) |->
		scl && !host_sda_oe && !dev_sda_oe)
		else $error("link not idle when reset is released");

	cover property (s_start ##[1:1000] dev_sda_oe);
endmodule
`default_nettype wire

/* test_serial_eeprom_bus_slave_interface.sv */
`timescale 1ns/100ps
`default_nettype none
module test_serial_eeprom_bus_slave_interface;
	import eeprom_link_pkg::*;
	// ---------------------------------------------------------------
	// Set-up
	// ---------------------------------------------------------------
	// The write cycle is kept longer than one address byte so that the
	// busy slave can be seen to refuse an address.
	localparam int unsigned PU    = 20;
	localparam int unsigned WR    = 14000;
	localparam logic [2:0]  STRAP = 3'h5;
	localparam logic [7:0]  AD_W  = {DEV_TYPE, STRAP, 1'b0};
	localparam logic [7:0]  AD_R  = {DEV_TYPE, STRAP, 1'b1};
	localparam logic [7:0]  AD_X  = {DEV_TYPE, STRAP ^ 3'h2, 1'b0};

	logic        sys_clk       = 1'b0;
	logic        rst           = 1'b1;
	logic        supply_ok     = 1'b1;
	logic [2:0]  straps        = STRAP;
	logic        write_inhibit = 1'b0;
	logic [7:0]  tx_data       = 8'hA6;
	logic [7:0]  paddr         = 8'h00;
	logic        psel          = 1'b0;
	logic        penable       = 1'b0;
	logic        pwrite        = 1'b0;
	logic [31:0] pwdata        = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        tx_taken;
	logic [7:0]  rx_data;
	logic        rx_valid;
	logic        write_commit;
	logic        write_busy;
	logic        dev_ready;
	logic [31:0] q;
	logic        e;
	int          n_errors      = 0;
	int          n_checks      = 0;
	int          n_rx          = 0;
	int          n_commit      = 0;
	int          n_tx          = 0;

	always #5 sys_clk = ~sys_clk;

	eeprom_link_if link ();

	eeprom_master_end #(.PU_CYC(PU)) i_eeprom_master_end (
		.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link)
	);

	eeprom_slave_end #(.PU_CYC(PU), .WR_CYC(WR)) i_eeprom_slave_end (
		.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .supply_ok(supply_ok),
		.select_strap_bit0(straps[0]), .select_strap_bit1(straps[1]),
		.select_strap_bit2(straps[2]), .write_inhibit(write_inhibit),
		.link(link), .tx_data(tx_data), .tx_taken(tx_taken),
		.rx_data(rx_data), .rx_valid(rx_valid), .write_commit(write_commit),
		.write_busy(write_busy), .dev_ready(dev_ready)
	);

	eeprom_link_sva i_eeprom_link_sva (
		.sys_clk(sys_clk), .rst(rst), .scl(link.scl),
		.host_sda_o(link.host_sda_o), .host_sda_oe(link.host_sda_oe),
		.dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe),
		.sda(link.sda)
	);

	always @(posedge sys_clk) begin
		n_rx <= n_rx + int'(rx_valid === 1'b1);
		n_commit <= n_commit + int'(write_commit === 1'b1);
		n_tx <= n_tx + int'(tx_taken === 1'b1);
	end

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic apb(input logic [7:0] a, input logic wr,
		input logic [31:0] d, output logic [31:0] rd, output logic err);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Polling covers the whole link operation, so a byte is done on return.
	task automatic op(input logic [1:0] c, input logic [7:0] d,
		input logic ack);
		logic [31:0] s;
		logic        x;
		if (c == CMD_WRITE)
			apb(DATA_OFS, 1'b1, {24'h0, d}, s, x);
		apb(CTRL_OFS, 1'b1, 32'(c) | (32'(ack) << CTRL_ACK_BIT), s, x);
		s = 32'h1;
		while (s[STAT_BUSY_BIT] !== 1'b0)
			apb(STAT_OFS, 1'b0, 32'h0, s, x);
	endtask

	task automatic wr_byte(input logic [7:0] d, input logic exp_ack);
		logic [31:0] s;
		logic        x;
		op(CMD_WRITE, d, 1'b0);
		apb(STAT_OFS, 1'b0, 32'h0, s, x);
		check("slave ack", 32'(s[STAT_ACK_BIT]), 32'(exp_ack));
	endtask

	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	// A clean run takes about 92,000 cycles, mostly link bits and the
	// write cycle, so this leaves a small margin.
	initial begin
		repeat (100000) @(posedge sys_clk);
		$display("unexpected run length: expected end, seen timeout");
		n_errors++;
		finish_test();
	end

	initial begin
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		check("idle sda", 32'(link.sda), 32'h1);
		q = 32'h0;
		while (q[STAT_READY_BIT] !== 1'b1)
			apb(STAT_OFS, 1'b0, 32'h0, q, e);
		// The slave sees the supply through its pin synchroniser, so it
		// gets ready two cycles after the master.
		repeat (3) @(posedge sys_clk);
		check("dev_ready", 32'(dev_ready), 32'h1);
		apb(8'h0C, 1'b0, 32'h0, q, e);
		check("unmapped error", 32'(e), 32'h1);
		check("unmapped data", q, 32'h0);
		$display("test reset and map done");

		op(CMD_START, 8'h00, 1'b0);
		wr_byte(AD_X, 1'b0);
		op(CMD_STOP, 8'h00, 1'b0);
		$display("test address mismatch done");

		op(CMD_START, 8'h00, 1'b0);
		wr_byte(AD_W, 1'b1);
		wr_byte(8'h01, 1'b1);
		wr_byte(8'h23, 1'b1);
		check("rx_data addr", 32'(rx_data), 32'h23);
		wr_byte(8'h5A, 1'b1);
		check("rx_data", 32'(rx_data), 32'h5A);
		write_inhibit <= 1'b1;
		wr_byte(8'hC3, 1'b0);
		write_inhibit <= 1'b0;
		check("rx count", 32'(n_rx), 32'd3);
		op(CMD_STOP, 8'h00, 1'b0);
		repeat (50) @(posedge sys_clk);
		check("commit count", 32'(n_commit), 32'd1);
		check("write busy", 32'(write_busy), 32'h1);
		op(CMD_START, 8'h00, 1'b0);
		wr_byte(AD_W, 1'b0);
		op(CMD_STOP, 8'h00, 1'b0);
		while (write_busy !== 1'b0)
			@(posedge sys_clk);
		$display("test write and inhibit done");

		op(CMD_START, 8'h00, 1'b0);
		wr_byte(AD_R, 1'b1);
		op(CMD_READ, 8'h00, 1'b0);
		apb(DATA_OFS, 1'b0, 32'h0, q, e);
		check("read byte", {24'h0, q[7:0]}, 32'hA6);
		check("tx count", 32'(n_tx), 32'd1);
		op(CMD_STOP, 8'h00, 1'b0);
		$display("test read done");

		supply_ok <= 1'b0;
		repeat (10) @(posedge sys_clk);
		check("dev_ready low", 32'(dev_ready), 32'h0);
		check("released sda", 32'(link.sda), 32'h1);
		supply_ok <= 1'b1;
		repeat (PU + 30) @(posedge sys_clk);
		check("dev_ready back", 32'(dev_ready), 32'h1);
		$display("test supply loss done");
		finish_test();
	end
endmodule
`default_nettype wire
